// File: inc/rate_limit_pkg.sv
// constants of the per-port, per-priority ingress rate limit register bank
package rate_limit_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int        NUM_PORTS   = 5;
  localparam int        NUM_PRI     = 4;
  localparam int        LIMIT_W     = 7;
  localparam int        SLICE_W     = NUM_PRI * LIMIT_W;
  localparam int        RSVD_BIT    = 7;
  localparam logic [1:0] PRI_COMMIT = 2'h3;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] LIMIT_BASE        = 8'hb7;
  localparam logic [7:0] PORT_STRIDE       = 8'h10;
  localparam logic [7:0] LIMIT_SPAN        = 8'h50;
  localparam logic [7:0] PORT1_PRI2_OFFSET = 8'hb9;
  localparam logic [7:0] PORT1_PRI3_OFFSET = 8'hba;
  localparam logic [7:0] PORT2_PRI2_OFFSET = 8'hc9;
  localparam logic [7:0] PORT2_PRI3_OFFSET = 8'hca;
  localparam logic [7:0] PORT3_PRI2_OFFSET = 8'hd9;
  localparam logic [7:0] PORT3_PRI3_OFFSET = 8'hda;
  localparam logic [7:0] PORT4_PRI2_OFFSET = 8'he9;
  localparam logic [7:0] PORT4_PRI3_OFFSET = 8'hea;
  localparam logic [7:0] PORT5_PRI1_OFFSET = 8'hf8;
  localparam logic [7:0] PORT5_PRI2_OFFSET = 8'hf9;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [LIMIT_W-1:0] LIMIT_RST  = 7'h00;
  localparam logic [7:0]         RDATA_RST  = 8'h00;

  // ----------------------------------------------------------------
  // shaper timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS = 4;
  localparam int          REFILL_NS     = 1000;
  localparam int          REFILL_CYC    = REFILL_NS / CLK_PERIOD_NS;
  localparam logic [15:0] CREDIT_MAX    = 16'h0800;

endpackage

// File: design/port_limit_slice.sv
// one port's pending and active limit codes for all four priorities
`timescale 1ns/1ns
module port_limit_slice (
  // clock and reset
  input  wire logic                                 clk,
  input  wire logic                                 srst,
  // register write
  input  wire logic                                 wr_en,
  input  wire logic [1:0]                           wr_pri,
  input  wire logic [rate_limit_pkg::LIMIT_W-1:0]   wr_data,
  // limit codes
  output logic      [rate_limit_pkg::SLICE_W-1:0]   pend_q,
  output logic      [rate_limit_pkg::SLICE_W-1:0]   act_q
);

  logic [rate_limit_pkg::SLICE_W-1:0] pend_d;
  logic [rate_limit_pkg::SLICE_W-1:0] act_d;

  // ----------------------------------------------------------------
  // pending store and commit
  // ----------------------------------------------------------------
  always_comb begin
    pend_d = pend_q;
    act_d  = act_q;
    if (wr_en) begin
      pend_d[wr_pri*rate_limit_pkg::LIMIT_W +: rate_limit_pkg::LIMIT_W] = wr_data;
    end
    // the priority 3 write carries its own code into the commit
    if (wr_en && wr_pri == rate_limit_pkg::PRI_COMMIT) begin
      act_d = pend_d;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pend_q <= {rate_limit_pkg::NUM_PRI{rate_limit_pkg::LIMIT_RST}};
      act_q  <= {rate_limit_pkg::NUM_PRI{rate_limit_pkg::LIMIT_RST}};
    end else begin
      pend_q <= pend_d;
      act_q  <= act_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  hold_until_commit_a : assert property (@(posedge clk) disable iff (srst)
    !(wr_en && wr_pri == rate_limit_pkg::PRI_COMMIT) |=> $stable(act_q))
    else $error("active limits changed without a commit write");

endmodule

// File: design/ingress_limit_regs.sv
// ingress rate limit register bank with per-port, per-priority shaper
`timescale 1ns/1ns
//
// Function
// - port 5 priority 1 limit: seven read/write bits, reset zero.
// - every port has a read/write seven-bit priority 2 limit field.
// - bit 7 of each limit register is reserved, reads zero, ignores writes.
// - ingress traffic per port and priority is shaped to the programmed limit.
// - any priority 3 write makes all that port's limits take effect.
// - each port has its own copies; next port lies sixteen addresses higher.
module ingress_limit_regs (
  // clock and reset
  input  wire logic                                    clk,
  input  wire logic                                    srst,
  // register access from the management interface
  input  wire logic                                    reg_wr,
  input  wire logic                                    reg_rd,
  input  wire logic [7:0]                              reg_addr,
  input  wire logic [7:0]                              reg_wdata,
  output logic      [7:0]                              reg_rdata_q,
  output logic                                         reg_rvalid_q,
  // ingress byte stream, one strobe and priority per port
  input  wire logic [rate_limit_pkg::NUM_PORTS-1:0]    ing_byte,
  input  wire logic [2*rate_limit_pkg::NUM_PORTS-1:0]  ing_pri,
  // shaper state
  output logic      [rate_limit_pkg::NUM_PORTS*rate_limit_pkg::SLICE_W-1:0] active_limit_q,
  output logic      [rate_limit_pkg::NUM_PORTS*rate_limit_pkg::NUM_PRI-1:0] hold_q
);

  localparam int NCNT = rate_limit_pkg::NUM_PORTS * rate_limit_pkg::NUM_PRI;
  localparam int LW   = rate_limit_pkg::LIMIT_W;
  localparam int SW   = rate_limit_pkg::SLICE_W;
  localparam int TICK_GAP = rate_limit_pkg::REFILL_CYC;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic [7:0]        rel_addr;
  logic [2:0]        sel_port;
  logic [1:0]        sel_pri;
  logic              addr_hit;
  logic [SW-1:0]     pend_w [rate_limit_pkg::NUM_PORTS];

  always_comb begin
    rel_addr = reg_addr - rate_limit_pkg::LIMIT_BASE;
    sel_port = rel_addr[6:4];
    sel_pri  = rel_addr[1:0];
    // port copies repeat every sixteen addresses, four priorities each
    addr_hit = (reg_addr >= rate_limit_pkg::LIMIT_BASE) &&
               (rel_addr < rate_limit_pkg::LIMIT_SPAN) &&
               (rel_addr[3:2] == 2'h0);
  end

  // ----------------------------------------------------------------
  // per-port limit storage
  // ----------------------------------------------------------------
  genvar gp;
  generate
    for (gp = 0; gp < rate_limit_pkg::NUM_PORTS; gp++) begin : g_port
      logic port_wr;
      assign port_wr = reg_wr && addr_hit && (sel_port == 3'(gp));
      port_limit_slice u_slice (
        .clk     (clk),
        .srst    (srst),
        .wr_en   (port_wr),
        .wr_pri  (sel_pri),
        .wr_data (reg_wdata[LW-1:0]),
        .pend_q  (pend_w[gp]),
        .act_q   (active_limit_q[gp*SW +: SW])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // read answer
  // ----------------------------------------------------------------
  logic [7:0] reg_rdata_d;
  logic       reg_rvalid_d;
  logic [SW-1:0] rd_slice;

  always_comb begin
    rd_slice     = pend_w[0];
    reg_rdata_d  = rate_limit_pkg::RDATA_RST;
    reg_rvalid_d = reg_rd;
    if (reg_rd && addr_hit) begin
      rd_slice    = pend_w[sel_port];
      reg_rdata_d = {1'b0, rd_slice[sel_pri*LW +: LW]};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata_q  <= rate_limit_pkg::RDATA_RST;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rdata_q  <= reg_rdata_d;
      reg_rvalid_q <= reg_rvalid_d;
    end
  end

  // ----------------------------------------------------------------
  // refill tick
  // ----------------------------------------------------------------
  logic [15:0] tick_cnt_q;
  logic [15:0] tick_cnt_d;
  logic        tick_q;
  logic        tick_d;

  always_comb begin
    tick_d     = 1'b0;
    tick_cnt_d = tick_cnt_q + 16'h0001;
    if (tick_cnt_q == 16'(rate_limit_pkg::REFILL_CYC - 1)) begin
      tick_cnt_d = 16'h0000;
      tick_d     = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tick_cnt_q <= 16'h0000;
      tick_q     <= 1'b0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      tick_q     <= tick_d;
    end
  end

  // ----------------------------------------------------------------
  // credit shaper, one bucket per port and priority
  // ----------------------------------------------------------------
  logic [15:0] credit_q [NCNT];
  logic [15:0] credit_d [NCNT];
  logic [NCNT-1:0] hold_d;

  genvar gc;
  generate
    for (gc = 0; gc < NCNT; gc++) begin : g_bucket
      localparam int P = gc / rate_limit_pkg::NUM_PRI;
      localparam int K = gc % rate_limit_pkg::NUM_PRI;
      logic [LW-1:0] lim;
      logic          take;
      logic [16:0]   sum;

      always_comb begin
        lim  = active_limit_q[gc*LW +: LW];
        take = ing_byte[P] && (ing_pri[2*P +: 2] == 2'(K));
        sum  = {1'b0, credit_q[gc]};
        // code zero leaves the priority unlimited
        if (lim == rate_limit_pkg::LIMIT_RST) begin
          sum = {1'b0, rate_limit_pkg::CREDIT_MAX};
        end else begin
          if (tick_q) begin
            sum = sum + {10'h000, lim};
          end
          if (sum > {1'b0, rate_limit_pkg::CREDIT_MAX}) begin
            sum = {1'b0, rate_limit_pkg::CREDIT_MAX};
          end
          if (take && sum != 17'h00000) begin
            sum = sum - 17'h00001;
          end
        end
        credit_d[gc] = sum[15:0];
        hold_d[gc]   = (lim != rate_limit_pkg::LIMIT_RST) && (sum == 17'h00000);
      end

      always_ff @(posedge clk) begin
        if (srst) begin
          credit_q[gc] <= rate_limit_pkg::CREDIT_MAX;
        end else begin
          credit_q[gc] <= credit_d[gc];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (srst) begin
      hold_q <= '0;
    end else begin
      hold_q <= hold_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence write_then_read_s;
    (reg_wr && addr_hit && !reg_rd) ##1 (reg_rd && !reg_wr && $stable(reg_addr));
  endsequence

  rd_answer_a : assert property (
    reg_rd |=> reg_rvalid_q)
    else $error("read not answered in one cycle");

  rsvd_zero_a : assert property (
    reg_rvalid_q |-> (reg_rdata_q[rate_limit_pkg::RSVD_BIT] == 1'b0))
    else $error("reserved bit read as one");

  write_readback_a : assert property (
    write_then_read_s |=> (reg_rdata_q == ($past(reg_wdata, 2) & 8'h7f)))
    else $error("read back differs from written limit");

  unmapped_zero_a : assert property (
    (reg_rd && !addr_hit) |=> (reg_rdata_q == 8'h00))
    else $error("unmapped address read nonzero");

  port5_pri1_a : assert property (
    (reg_wr && reg_addr == rate_limit_pkg::PORT5_PRI1_OFFSET) |=>
      (pend_w[4][LW +: LW] == $past(reg_wdata[LW-1:0])))
    else $error("port 5 priority 1 limit not stored");

  stride_a : assert property (
    (reg_wr && reg_addr == rate_limit_pkg::PORT2_PRI2_OFFSET) |=>
      (pend_w[1][2*LW +: LW] == $past(reg_wdata[LW-1:0])) && $stable(pend_w[0]))
    else $error("port 2 copy not separate from port 1");

  commit_a : assert property (
    (reg_wr && reg_addr == rate_limit_pkg::PORT1_PRI3_OFFSET) |=>
      (active_limit_q[SW-1:0] == pend_w[0]))
    else $error("commit write did not apply pending limits");

  pending_only_a : assert property (
    (reg_wr && reg_addr == rate_limit_pkg::PORT1_PRI2_OFFSET && !$rose(tick_q)) |=>
      $stable(active_limit_q[SW-1:0]))
    else $error("priority 2 write changed active limit");

  unlimited_a : assert property (
    (active_limit_q[LW-1:0] == rate_limit_pkg::LIMIT_RST) |=> !hold_q[0])
    else $error("unlimited priority held");

  tick_period_a : assert property (
    tick_q |=> !tick_q [*3])
    else $error("refill tick too frequent");

  // ----------------------------------------------------------------
  // reset, commit, read and shaper checks
  // ----------------------------------------------------------------
  sequence commit_wr_s;
    reg_wr && addr_hit && (sel_pri == rate_limit_pkg::PRI_COMMIT);
  endsequence

  sequence bucket4_take_s;
    ing_byte[1] && (ing_pri[3:2] == 2'h0) && !tick_q && (credit_q[4] != 16'h0000) &&
      (active_limit_q[4*LW +: LW] != rate_limit_pkg::LIMIT_RST);
  endsequence

  sequence bucket4_refill_s;
    tick_q && !ing_byte[1] && (active_limit_q[4*LW +: LW] != rate_limit_pkg::LIMIT_RST);
  endsequence

  reset_clear_a : assert property (disable iff (1'b0)
    srst |=> (active_limit_q == '0) && (hold_q == '0) && !reg_rvalid_q &&
      (reg_rdata_q == rate_limit_pkg::RDATA_RST))
    else $error("outputs not cleared by reset");

  commit_any_a : assert property (
    commit_wr_s |=> (active_limit_q[$past(sel_port)*SW +: SW] == pend_w[$past(sel_port)]))
    else $error("commit write did not apply that port's pending limits");

  commit_data_a : assert property (
    (reg_wr && reg_addr == rate_limit_pkg::PORT1_PRI3_OFFSET) |=>
      (active_limit_q[3*LW +: LW] == $past(reg_wdata[LW-1:0])))
    else $error("commit write did not use its own priority 3 code");

  commit_port2_a : assert property (
    (reg_wr && reg_addr == rate_limit_pkg::PORT2_PRI3_OFFSET) |=>
      (active_limit_q[SW +: SW] == pend_w[1]) && $stable(active_limit_q[SW-1:0]))
    else $error("port 2 commit wrong or leaked into port 1");

  commit_only_a : assert property (
    !(reg_wr && addr_hit && (sel_pri == rate_limit_pkg::PRI_COMMIT)) |=> $stable(active_limit_q))
    else $error("active limits changed without a commit write");

  rd_data_a : assert property (
    (reg_rd && addr_hit) |=> (reg_rdata_q == {1'b0, $past(pend_w[sel_port][sel_pri*LW +: LW])}))
    else $error("read answer differs from stored limit");

  rvalid_pulse_a : assert property (
    !reg_rd |=> !reg_rvalid_q)
    else $error("read answer without a read");

  tick_reload_a : assert property (
    tick_q |-> (tick_cnt_q == 16'h0000))
    else $error("refill tick out of step with its counter");

  tick_range_a : assert property (
    tick_cnt_q < 16'(rate_limit_pkg::REFILL_CYC))
    else $error("refill counter ran past its period");

  tick_spacing_a : assert property (
    tick_q |-> ##TICK_GAP tick_q)
    else $error("refill tick missed its period");

  credit_cap_a : assert property (
    credit_q[4] <= rate_limit_pkg::CREDIT_MAX)
    else $error("credit above its cap");

  byte_spend_a : assert property (
    bucket4_take_s |=> (credit_q[4] == $past(credit_q[4]) - 16'h0001))
    else $error("admitted byte did not spend one credit");

  refill_release_a : assert property (
    bucket4_refill_s |=> !hold_q[4])
    else $error("refill did not release the hold");

  hold_limited_a : assert property (
    hold_q[4] |-> ($past(active_limit_q[4*LW +: LW]) != rate_limit_pkg::LIMIT_RST))
    else $error("hold raised for an unlimited priority");

endmodule

// File: test/tb.sv
// self-checking bench for the ingress rate limit register bank
`timescale 1ns/1ns
module tb;
  logic        clk;
  logic        srst;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata_q;
  logic        reg_rvalid_q;
  logic [4:0]  ing_byte;
  logic [9:0]  ing_pri;
  logic [139:0] active_limit_q;
  logic [19:0] hold_q;
  int          fails;
  int          checks_done;

  ingress_limit_regs dut (
    .clk            (clk),
    .srst           (srst),
    .reg_wr         (reg_wr),
    .reg_rd         (reg_rd),
    .reg_addr       (reg_addr),
    .reg_wdata      (reg_wdata),
    .reg_rdata_q    (reg_rdata_q),
    .reg_rvalid_q   (reg_rvalid_q),
    .ing_byte       (ing_byte),
    .ing_pri        (ing_pri),
    .active_limit_q (active_limit_q),
    .hold_q         (hold_q)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    chk({7'h00, reg_rvalid_q}, 8'h01);
    chk(reg_rdata_q, exp);
  endtask

  function automatic logic [7:0] act(input int p, input int k);
    return {1'b0, active_limit_q[p*28+k*7 +: 7]};
  endfunction

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic reset_values();
    rd(8'hf8, 8'h00);
    for (int i = 0; i < 5; i++) begin
      rd(8'hb9 + 8'h10 * i[7:0], 8'h00);
    end
    rd(8'hbb, 8'h00);
  endtask

  task automatic per_port_copies();
    for (int i = 0; i < 5; i++) begin
      wr(8'hb9 + 8'h10 * i[7:0], 8'h80 | (8'h11 + i[7:0]));
    end
    for (int i = 0; i < 5; i++) begin
      rd(8'hb9 + 8'h10 * i[7:0], 8'h11 + i[7:0]);
    end
    wr(8'hf8, 8'hff);
    rd(8'hf8, 8'h7f);
    wr(8'hea, 8'hff);
    rd(8'hea, 8'h7f);
    wr(8'hbb, 8'h55);
    rd(8'hbb, 8'h00);
  endtask

  task automatic write_then_read();
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= 8'hd9;
    reg_wdata <= 8'hab;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b1;
    @(posedge clk);
    reg_rd    <= 1'b0;
    #1;
    chk({7'h00, reg_rvalid_q}, 8'h01);
    chk(reg_rdata_q, 8'h2b);
  endtask

  task automatic commit_port1();
    wr(8'hb7, 8'h11);
    wr(8'hb8, 8'h22);
    wr(8'hb9, 8'h33);
    #1;
    chk(act(0, 2), 8'h00);
    wr(8'hba, 8'hc4);
    #1;
    chk(act(0, 0), 8'h11);
    chk(act(0, 1), 8'h22);
    chk(act(0, 2), 8'h33);
    chk(act(0, 3), 8'h44);
    chk(act(1, 2), 8'h00);
    wr(8'hb9, 8'h05);
    #1;
    chk(act(0, 2), 8'h33);
    rd(8'hb9, 8'h05);
  endtask

  task automatic shaping();
    int n;
    wr(8'hc7, 8'h01);
    wr(8'hca, 8'h00);
    @(posedge clk);
    // egress queue setup lies outside this bench; only priority 0 bytes are sent, on ports 2 and 5
    ing_byte <= 5'h12;
    ing_pri  <= 10'h000;
    n = 0;
    while (hold_q[4] !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    #1;
    chk({7'h00, hold_q[4]}, 8'h01);
    chk({7'h00, hold_q[5]}, 8'h00);
    chk({7'h00, hold_q[16]}, 8'h00);
    if (n >= 3000) begin
      fails++;
      tally_and_finish();
    end
    @(posedge clk);
    ing_byte <= 5'h00;
    n = 0;
    while (hold_q[4] !== 1'b0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    #1;
    chk({7'h00, hold_q[4]}, 8'h00);
    if (n >= 300) begin
      fails++;
      tally_and_finish();
    end
  endtask

  initial begin
    fails       = 0;
    checks_done = 0;
    srst        = 1'b1;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    reg_addr    = 8'h00;
    reg_wdata   = 8'h00;
    ing_byte    = 5'h00;
    ing_pri     = 10'h000;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    reset_values();
    per_port_copies();
    write_then_read();
    commit_port1();
    shaping();
    tally_and_finish();
  end
endmodule
